// ==== verilog/rfid_regs_consts.svh ====
// Offsets, bit positions, reset values and levels of the reader test and FIFO register group.
`ifndef RFID_REGS_CONSTS_SVH
`define RFID_REGS_CONSTS_SVH
`define OFS_TEST_RX_PATH 5'h1A
`define OFS_TEST_MODE 5'h1B
`define OFS_FIFO_STATUS 5'h1C
`define OFS_TX_LEN_HIGH 5'h1D
`define OFS_TX_LEN_LOW 5'h1E
`define RST_REG 8'h00
`define RD_UNMAPPED 8'h00
`define TR_KEYING_IN 7
`define TR_SUBC_OUT 6
`define TR_DIRECT_TX 5
`define TR_STAGE_SEL 4
`define TR_CUT_TWO 3
`define TR_CUT_ONE 2
`define TR_FOLLOWER 1
`define TR_AGC_PROBE 0
`define TM_RF_LEVEL 7
`define TM_PROBE_HI 3
`define TM_PROBE_LO 2
`define TM_DEC_TEST 1
`define TM_FAST_CLK 0
`define TM_STOP_MASK 8'h0E
`define FIFO_HIGH_LEVEL 5'h09
`define FIFO_LOW_LEVEL 5'h03
`define FIFO_DEPTH_DEF 16
`define FIFO_WIDTH_DEF 8
`endif

// ==== verilog/rfid_regs_pkg.sv ====
// Types shared by the reader test and FIFO register group.
package rfid_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] reg_addr_t;
  typedef logic [2:0] level_t;
endpackage : rfid_regs_pkg

// ==== verilog/fifo_status_txlen_test_regs.sv ====
// Reader test controls, FIFO status, transmit length registers and their data FIFO.
// Operation
// RULE1: Test registers clear on reset or enable low.
// RULE2: Keying pin feeds decoder when bit7 set.
// RULE3: Shaping pin drives digitized subcarrier on bit6.
// RULE4: Shaping pin becomes direct modulation, receiver reset.
// RULE5: Stage select picks first or second stage.
// RULE6: Gain cut bits drop gain, halve corner.
// RULE7: Gain probe shows gain level on strength.
// RULE8: Decoder or I/O test bit enters test mode.
// RULE9: Stop condition clears decoder and I/O bits.
// RULE10: Bit0 clocks coders at full reference rate.
// RULE11: Status bit7 always reads zero.
// RULE12: FIFO-high flag at nine bytes during reception.
// RULE13: FIFO-low flag at three bytes during transmission.
// RULE14: Overflow flag when writes exceed FIFO room.
// RULE15: Low status nibble shows unread bytes minus one.
// RULE16: Length registers clear on reset and frame end.
// RULE17: Twelve-bit byte count split across two registers.
// RULE18: Partial bit count used only with flag.
// RULE19: Flag bit0 marks short final byte.
// RULE20: Main strength field is three bits wide.
`include "rfid_regs_consts.svh"

// ****************************************************************
// Data FIFO
// ****************************************************************
module data_fifo #(
  parameter int WIDTH = `FIFO_WIDTH_DEF,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so both are exact.
  assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign level = s_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap because the depth is a power of two.
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (rst || flush)
    begin
      s_nxt = '0;
    end
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    s_r <= s_nxt;
  end
endmodule : data_fifo

// ****************************************************************
// Register group
// ****************************************************************
module fifo_status_txlen_test_regs #(
  parameter int FIFO_WIDTH = `FIFO_WIDTH_DEF,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  // Clock, reset and chip enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_en,
  // Register port from the host interface
  input wire rfid_regs_pkg::reg_addr_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire rfid_regs_pkg::reg_byte_t reg_wdata,
  output rfid_regs_pkg::reg_byte_t reg_rdata,
  // Frame events
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic tx_eof,
  input wire logic stop_cond,
  input wire logic fifo_flush,
  // FIFO fill side
  input wire logic fill_valid,
  output logic fill_ready,
  input wire logic [FIFO_WIDTH-1:0] fill_data,
  // FIFO drain side
  output logic drain_valid,
  input wire logic drain_ready,
  output logic [FIFO_WIDTH-1:0] drain_data,
  // Keying pin
  input wire logic keying_pin_in,
  output logic keying_pin_decoder_input,
  output logic decoder_ext_sel,
  // Shaping pin
  input wire logic shaping_pin_in,
  output logic shaping_pin_out,
  output logic shaping_pin_oe,
  input wire logic shape_drive,
  input wire logic rx_subcarrier,
  output logic shaping_pin_direct_tx,
  output logic rx_reset,
  // Receiver analog controls
  output logic stage_sel,
  output logic stage_one_gain_cut,
  output logic stage_two_gain_cut,
  output logic stage_one_corner_half,
  output logic stage_two_corner_half,
  output logic follower_test,
  // Strength field
  input wire rfid_regs_pkg::level_t rssi_main,
  input wire rfid_regs_pkg::level_t agc_level,
  output rfid_regs_pkg::level_t rssi_main_shown,
  // Test mode and coder clock
  output logic test_mode,
  output logic coder_fast_clock,
  output logic rf_amplitude_probe,
  // Transmit length
  output logic [11:0] tx_byte_count,
  output logic [2:0] tx_partial_bits,
  output logic tx_partial_flag
);
  import rfid_regs_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    reg_byte_t test_rx_path_ctrl;
    reg_byte_t test_mode_ctrl;
    reg_byte_t tx_length_high;
    reg_byte_t tx_length_low_partial;
    logic ovf;
    reg_byte_t rdata;
  } regs_st_t;
  regs_st_t s_r;
  regs_st_t s_nxt;
  logic [LW-1:0] level;
  logic fifo_high;
  logic fifo_low;
  logic [3:0] unread_m1;
  reg_byte_t fifo_level_status;
  logic clr;

  // Address match, used by every register decode.
  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    hit = a == ofs;
  endfunction : hit

  data_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(clr),
    .flush(fifo_flush),
    .in_valid(fill_valid),
    .in_ready(fill_ready),
    .in_data(fill_data),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_data),
    .level(level)
  );

  // Power-on reset and enable low both return the group to its defaults.
  assign clr = rst || !chip_en; // RULE1

  // FIFO-high and FIFO-low flags follow the live FIFO level; the overflow flag is held in a register.
  assign fifo_high = rx_active && (level >= LW'(`FIFO_HIGH_LEVEL)); // RULE12
  assign fifo_low = tx_active && (level <= LW'(`FIFO_LOW_LEVEL)); // RULE13
  // An empty FIFO reads as zero, the same as one byte; N-1 cannot go below it.
  assign unread_m1 = (level == '0) ? 4'h0 : 4'((level - 1'b1)); // RULE15
  assign fifo_level_status = {1'b0, fifo_high, fifo_low, s_r.ovf, unread_m1}; // RULE11

  // Next state: stop and frame-end clears come first, so a host write in the same cycle wins; reset and enable low come last and win over it.
  always_comb
  begin
    s_nxt = s_r;
    if (stop_cond)
    begin
      s_nxt.test_mode_ctrl = s_r.test_mode_ctrl & ~`TM_STOP_MASK; // RULE9
    end
    if (tx_eof)
    begin
      s_nxt.tx_length_high = `RST_REG; // RULE16
      s_nxt.tx_length_low_partial = `RST_REG; // RULE16
    end
    if (fifo_flush)
    begin
      s_nxt.ovf = 1'b0;
    end
    if (fill_valid && !fill_ready)
    begin
      s_nxt.ovf = 1'b1; // RULE14
    end
    if (reg_wr && hit(reg_addr, `OFS_TEST_RX_PATH))
    begin
      s_nxt.test_rx_path_ctrl = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `OFS_TEST_MODE))
    begin
      s_nxt.test_mode_ctrl = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `OFS_TX_LEN_HIGH))
    begin
      s_nxt.tx_length_high = reg_wdata; // RULE17
    end
    if (reg_wr && hit(reg_addr, `OFS_TX_LEN_LOW))
    begin
      s_nxt.tx_length_low_partial = reg_wdata; // RULE17
    end
    if (reg_rd)
    begin
      s_nxt.rdata = `RD_UNMAPPED;
      if (hit(reg_addr, `OFS_TEST_RX_PATH))
        s_nxt.rdata = s_r.test_rx_path_ctrl;
      if (hit(reg_addr, `OFS_TEST_MODE))
        s_nxt.rdata = s_r.test_mode_ctrl;
      if (hit(reg_addr, `OFS_FIFO_STATUS))
        s_nxt.rdata = fifo_level_status;
      if (hit(reg_addr, `OFS_TX_LEN_HIGH))
        s_nxt.rdata = s_r.tx_length_high;
      if (hit(reg_addr, `OFS_TX_LEN_LOW))
        s_nxt.rdata = s_r.tx_length_low_partial;
    end
    if (clr)
    begin
      s_nxt = '0; // RULE1 RULE16
    end
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;

  // Keying pin becomes the decoder's digital input.
  assign decoder_ext_sel = s_r.test_rx_path_ctrl[`TR_KEYING_IN]; // RULE2
  assign keying_pin_decoder_input = decoder_ext_sel && keying_pin_in; // RULE2

  // Shaping pin: subcarrier out outranks direct mode, which turns the pin into an input.
  always_comb
  begin
    shaping_pin_out = shape_drive;
    shaping_pin_oe = 1'b1;
    shaping_pin_direct_tx = 1'b0;
    rx_reset = 1'b0;
    if (s_r.test_rx_path_ctrl[`TR_SUBC_OUT])
    begin
      shaping_pin_out = rx_subcarrier; // RULE3
    end
    else if (s_r.test_rx_path_ctrl[`TR_DIRECT_TX])
    begin
      shaping_pin_out = 1'b0;
      shaping_pin_oe = 1'b0; // RULE4
      shaping_pin_direct_tx = shaping_pin_in; // RULE4
      rx_reset = shaping_pin_in; // RULE4
    end
  end

  // Receiver analog controls; each gain cut also halves its high-pass corner.
  assign stage_sel = s_r.test_rx_path_ctrl[`TR_STAGE_SEL]; // RULE5
  assign stage_two_gain_cut = s_r.test_rx_path_ctrl[`TR_CUT_TWO]; // RULE6
  assign stage_one_gain_cut = s_r.test_rx_path_ctrl[`TR_CUT_ONE]; // RULE6
  assign stage_two_corner_half = stage_two_gain_cut; // RULE6
  assign stage_one_corner_half = stage_one_gain_cut; // RULE6
  assign follower_test = s_r.test_rx_path_ctrl[`TR_FOLLOWER];

  // The three-bit main strength field is borrowed by the gain probe.
  assign rssi_main_shown = s_r.test_rx_path_ctrl[`TR_AGC_PROBE] ? // RULE7 RULE20
    agc_level : rssi_main;

  // Test mode lasts as long as the decoder test bit, TM_PROBE_HI or TM_PROBE_LO survives the stop clear; the RF level probe bit does not count.
  assign test_mode = |(s_r.test_mode_ctrl & `TM_STOP_MASK); // RULE8
  assign coder_fast_clock = s_r.test_mode_ctrl[`TM_FAST_CLK]; // RULE10
  assign rf_amplitude_probe = s_r.test_mode_ctrl[`TM_RF_LEVEL];

  // Length fields; the partial count is masked unless the short-byte flag is set.
  assign tx_byte_count = {s_r.tx_length_high, s_r.tx_length_low_partial[7:4]}; // RULE17
  assign tx_partial_flag = s_r.tx_length_low_partial[0]; // RULE19
  assign tx_partial_bits = tx_partial_flag ? s_r.tx_length_low_partial[3:1] : 3'h0; // RULE18

  // ****************************************************************
  // Checks
  // ****************************************************************
  enable_clear_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    !chip_en |=> (s_r.test_rx_path_ctrl == 8'h00) && (s_r.test_mode_ctrl == 8'h00))
    else $error("test registers not cleared with enable low");
  keying_route_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    s_r.test_rx_path_ctrl[7] |-> keying_pin_decoder_input == keying_pin_in)
    else $error("keying pin not routed to decoder");
  subc_drive_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
    s_r.test_rx_path_ctrl[6] |-> shaping_pin_oe && (shaping_pin_out == rx_subcarrier))
    else $error("subcarrier not driven on shaping pin");
  direct_in_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
    (s_r.test_rx_path_ctrl[6:5] == 2'b01) |-> !shaping_pin_oe && (rx_reset == shaping_pin_in))
    else $error("direct mode pin handling wrong");
  agc_show_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
    chip_en && reg_wr && (reg_addr == 5'h1A) && reg_wdata[0] |=> rssi_main_shown == agc_level)
    else $error("gain level not shown on strength bits");
  mode_hold_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
    test_mode && chip_en && !stop_cond && !(reg_wr && (reg_addr == 5'h1B)) |=> test_mode)
    else $error("test mode dropped without stop");
  stop_clear_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
    stop_cond && !(reg_wr && (reg_addr == 5'h1B)) |=> !test_mode)
    else $error("stop did not end test mode");
  status_read_a: assert property (@(posedge mclk) disable iff (rst) // RULE11 RULE15
    chip_en && reg_rd && (reg_addr == 5'h1C) && (level == 5'd8) |=> reg_rdata[7] == 1'b0
    && reg_rdata[3:0] == 4'h7)
    else $error("status read wrong for eight bytes");
  high_flag_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
    rx_active && (level == 5'd8) |-> !fifo_high)
    else $error("high flag set below nine bytes");
  overflow_a: assert property (@(posedge mclk) disable iff (rst) // RULE14
    chip_en && fill_valid && !fill_ready |=> s_r.ovf)
    else $error("overflow not flagged");
  eof_clear_a: assert property (@(posedge mclk) disable iff (rst) // RULE16
    chip_en && tx_eof && !reg_wr |=> (tx_byte_count == 12'h000) && !tx_partial_flag)
    else $error("length not cleared at frame end");
  stage_pick_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    chip_en && reg_wr && (reg_addr == 5'h1A) && reg_wdata[4] |=> stage_sel)
    else $error("stage select not applied");
  gain_cut_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
    chip_en && reg_wr && (reg_addr == 5'h1A) && reg_wdata[2]
    |=> stage_one_gain_cut && stage_one_corner_half)
    else $error("first stage cut not applied");
  fast_clock_a: assert property (@(posedge mclk) disable iff (rst) // RULE10
    chip_en && reg_wr && (reg_addr == 5'h1B) && reg_wdata[0] |=> coder_fast_clock)
    else $error("coder clock select not applied");
  high_read_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
    chip_en && rx_active && reg_rd && (reg_addr == 5'h1C) && (level == 5'h09) |=> reg_rdata[6])
    else $error("high flag not read at nine bytes");
  low_read_a: assert property (@(posedge mclk) disable iff (rst) // RULE13
    chip_en && tx_active && reg_rd && (reg_addr == 5'h1C) && (level == 5'h03) |=> reg_rdata[5])
    else $error("low flag not read at three bytes");
  partial_mask_a: assert property (@(posedge mclk) disable iff (rst) // RULE18
    chip_en && reg_wr && (reg_addr == 5'h1E) && !reg_wdata[0] |=> tx_partial_bits == 3'h0)
    else $error("partial bits not masked");
  partial_flag_a: assert property (@(posedge mclk) disable iff (rst) // RULE19
    chip_en && reg_wr && (reg_addr == 5'h1E) && reg_wdata[0] |=> tx_partial_flag)
    else $error("short byte flag not taken");
endmodule : fifo_status_txlen_test_regs

// ==== test/host_bus_model.sv ====
// Host model that reaches the register group through its register port.
module host_bus_model (
  // Clock
  input wire logic mclk,
  // Register port
  output rfid_regs_pkg::reg_addr_t reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output rfid_regs_pkg::reg_byte_t reg_wdata,
  input wire rfid_regs_pkg::reg_byte_t reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfid_regs_pkg::*;

  // Idle bus; strobes low from time zero.
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write; released lines show the inverse so a stale value never looks valid.
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // One read; data is registered, so it is taken after the sampling edge.
  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : host_bus_model

// ==== test/tb_top.sv ====
// Self-checking bench of the reader test, FIFO status and transmit length registers.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rfid_regs_pkg::*;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic mclk = 1'b0, rst = 1'b1, chip_en = 1'b1;
  reg_addr_t reg_addr;
  logic reg_wr, reg_rd;
  reg_byte_t reg_wdata, reg_rdata;
  logic rx_active = 0, tx_active = 0, tx_eof = 0, stop_cond = 0, fifo_flush = 0;
  logic fill_valid = 0, fill_ready, drain_valid, drain_ready = 0;
  logic [7:0] fill_data = 8'h00, drain_data;
  logic keying_pin_in = 0, keying_pin_decoder_input, decoder_ext_sel;
  logic shaping_pin_in = 0, shaping_pin_out, shaping_pin_oe, shape_drive = 1, rx_subcarrier = 0;
  logic shaping_pin_direct_tx, rx_reset, stage_sel, stage_one_gain_cut, stage_two_gain_cut;
  logic stage_one_corner_half, stage_two_corner_half, follower_test;
  level_t rssi_main = 3'h5, agc_level = 3'h2, rssi_main_shown;
  logic test_mode, coder_fast_clock, rf_amplitude_probe, tx_partial_flag;
  logic [11:0] tx_byte_count;
  logic [2:0] tx_partial_bits;
  int errors = 0, n_tests = 0;

  fifo_status_txlen_test_regs DUT (.mclk(mclk), .rst(rst), .chip_en(chip_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_active(rx_active), .tx_active(tx_active), .tx_eof(tx_eof),
    .stop_cond(stop_cond), .fifo_flush(fifo_flush), .fill_valid(fill_valid),
    .fill_ready(fill_ready), .fill_data(fill_data), .drain_valid(drain_valid),
    .drain_ready(drain_ready), .drain_data(drain_data), .keying_pin_in(keying_pin_in),
    .keying_pin_decoder_input(keying_pin_decoder_input), .decoder_ext_sel(decoder_ext_sel),
    .shaping_pin_in(shaping_pin_in), .shaping_pin_out(shaping_pin_out),
    .shaping_pin_oe(shaping_pin_oe), .shape_drive(shape_drive), .rx_subcarrier(rx_subcarrier),
    .shaping_pin_direct_tx(shaping_pin_direct_tx), .rx_reset(rx_reset), .stage_sel(stage_sel),
    .stage_one_gain_cut(stage_one_gain_cut), .stage_two_gain_cut(stage_two_gain_cut),
    .stage_one_corner_half(stage_one_corner_half),
    .stage_two_corner_half(stage_two_corner_half), .follower_test(follower_test),
    .rssi_main(rssi_main), .agc_level(agc_level), .rssi_main_shown(rssi_main_shown),
    .test_mode(test_mode), .coder_fast_clock(coder_fast_clock),
    .rf_amplitude_probe(rf_amplitude_probe), .tx_byte_count(tx_byte_count),
    .tx_partial_bits(tx_partial_bits), .tx_partial_flag(tx_partial_flag));
  host_bus_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rchk(input reg_addr_t a, input reg_byte_t exp);
    reg_byte_t d;
    host.rd(a, d);
    chk($sformatf("register %h", a), exp, d);
  endtask : rchk
  // Pulses last one cycle, falling edge to falling edge, so each strobe spans a single rising edge.
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  task automatic push(input logic [7:0] d);
    @(negedge mclk);
    fill_valid = 1'b1;
    fill_data = d;
    @(negedge mclk);
    fill_valid = 1'b0;
    fill_data = ~d;
  endtask : push
  // The drain side stalls a cycle before every pop.
  task automatic pop(input logic [7:0] exp);
    @(negedge mclk);
    chk("drain_data", {4'h1, exp}, {3'h0, drain_valid, drain_data});
    drain_ready = 1'b1;
    @(negedge mclk);
    drain_ready = 1'b0;
  endtask : pop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rchk(reg_addr_t'(5'h1A + i), 8'h00);
    rchk(5'h05, 8'h00);
    host.wr(5'h1A, 8'hFF);
    host.wr(5'h1B, 8'h8F);
    rchk(5'h1A, 8'hFF);
    rchk(5'h1B, 8'h8F);
    @(negedge mclk);
    chip_en = 1'b0;
    @(negedge mclk);
    chip_en = 1'b1;
    rchk(5'h1A, 8'h00);
    rchk(5'h1B, 8'h00);
  endtask : t_reset
  task automatic t_rxpath;
    host.wr(5'h1A, 8'h80);
    keying_pin_in = 1'b1;
    #1 chk("keying", 2'b11, {keying_pin_decoder_input, decoder_ext_sel});
    host.wr(5'h1A, 8'h40);
    rx_subcarrier = 1'b1;
    #1 chk("subc out", 3'b110,
      {shaping_pin_out, shaping_pin_oe, keying_pin_decoder_input});
    host.wr(5'h1A, 8'h20);
    shaping_pin_in = 1'b1;
    #1 chk("direct", 3'b011, {shaping_pin_oe, shaping_pin_direct_tx, rx_reset});
    host.wr(5'h1A, 8'h1C);
    #1 chk("stages", 6'h3E, {stage_sel, stage_two_gain_cut, stage_one_gain_cut,
      stage_two_corner_half, stage_one_corner_half, follower_test});
    host.wr(5'h1A, 8'h03);
    #1 chk("stages", 6'h01, {stage_sel, stage_two_gain_cut, stage_one_gain_cut,
      stage_two_corner_half, stage_one_corner_half, follower_test});
    chk("agc shown", 3'h2, rssi_main_shown);
    host.wr(5'h1A, 8'h00);
    #1 chk("rssi shown", 3'h5, rssi_main_shown);
    chk("shaping idle", 4'hC, {shaping_pin_out, shaping_pin_oe, shaping_pin_direct_tx, rx_reset});
  endtask : t_rxpath
  task automatic t_testmode;
    for (int i = 1; i < 4; i++)
    begin
      host.wr(5'h1B, 8'h81 | (8'h01 << i));
      chk("test_mode", 1'b1, test_mode);
      pulse(stop_cond);
      chk("test_mode", 1'b0, test_mode);
      rchk(5'h1B, 8'h81);
      chk("fast clock", 2'b11, {coder_fast_clock, rf_amplitude_probe});
    end
  endtask : t_testmode
  task automatic t_fifo;
    rx_active = 1'b1;
    for (int i = 0; i < 8; i++) push(8'h10 + i);
    rchk(5'h1C, 8'h07);
    push(8'h18);
    rchk(5'h1C, 8'h48);
    for (int i = 9; i < 17; i++) push(8'h10 + i);
    chk("fill_ready", 1'b0, fill_ready);
    rchk(5'h1C, 8'h5F);
    host.wr(5'h1C, 8'hFF);
    rx_active = 1'b0;
    tx_active = 1'b1;
    for (int i = 0; i < 12; i++) pop(8'h10 + i);
    rchk(5'h1C, 8'h13);
    pop(8'h1C);
    rchk(5'h1C, 8'h32);
    for (int i = 13; i < 16; i++) pop(8'h10 + i);
    pulse(fifo_flush);
    rchk(5'h1C, 8'h20);
    tx_active = 1'b0;
  endtask : t_fifo
  task automatic t_txlen;
    host.wr(5'h1D, 8'hAB);
    host.wr(5'h1E, 8'hC7);
    chk("tx count", 12'hABC, tx_byte_count);
    chk("partial", 4'hB, {tx_partial_flag, tx_partial_bits});
    host.wr(5'h1E, 8'hC6);
    chk("partial", 4'h0, {tx_partial_flag, tx_partial_bits});
    pulse(tx_eof);
    rchk(5'h1D, 8'h00);
    rchk(5'h1E, 8'h00);
  endtask : t_txlen

  task automatic stop_test;
    $display("Checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Main sequence after five reset cycles.
  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_rxpath();
    t_testmode();
    t_fifo();
    t_txlen();
    stop_test();
  end

  // Watchdog at 5000 cycles, well beyond the roughly 150 cycles the scenarios need.
  initial
  begin
    #50000;
    errors++;
    stop_test();
  end
endmodule : tb_top
